// ==== insn_decoder.v ====
// Instruction length decoder and classifier for the 16-bit core.
// Assumes fetch words on the core clock; cond_true from the datapath, same clock.
//
// Contract
// - Add and subtract, with or without carry, word or byte, 2 or 4 bytes.
// - Product multiplies two named registers 16x16, signed or unsigned, 2 bytes.
// - Short quotient divides low half; long quotient divides full 32-bit register.
// - Single bit write is 2 bytes; bit copy, logic, compare are 4 bytes.
// - Masked byte modify changes masked bits of high or low byte, 4 bytes.
// - Compare then step register down or up by one or two.
// - Normalize count is decoded as no effect, so it writes no shift count, 2 bytes.
// - Shifts, rotates and sign shift right are 2 bytes; sign bit replicated.
// - Byte to word extension fills upper byte with sign or zeros, 2 or 4.
// - Conditional branches and calls are 4 bytes, act only when condition holds.
// - Bit branches may clear or set the tested bit by variant, 4 bytes.
// - Trap invokes the service routine chosen by an immediate number, 2 bytes.
// - Context switch pushes a register then loads it with the operand, 4 bytes.
// - Push and enter pushes a register then calls absolute, 4 bytes.
// - Intra segment return resumes caller, optionally pops a register, 2 bytes.
// - Page and segment openers, 2 or 4 bytes, apply to following instructions.
// - Legacy sleep is recognised, takes 4 bytes, does nothing.
`timescale 1ns/1ps
`include "isd_consts.vh"

module insn_decoder (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Fetch word stream
  input wire fw_valid,
  input wire [15:0] fw_data,
  output reg fetch_ready_r,
  // Early length
  output reg len_valid_r,
  output reg len_four_r,
  // Datapath condition
  input wire cond_true,
  // Decoded instruction
  output reg dec_valid_r,
  output reg [5:0] op_class_r,
  output reg byte_op_r,
  output reg use_carry_r,
  output reg subtract_r,
  output reg unsigned_op_r,
  output reg low_half_only_r,
  output reg [1:0] variant_r,
  output reg bit_negate_r,
  output reg bit_side_write_r,
  output reg bit_side_value_r,
  output reg byte_high_r,
  output reg step_up_r,
  output reg step_two_r,
  output reg shift_right_r,
  output reg shift_arith_r,
  output reg zero_extend_r,
  output reg branch_en_r,
  output reg subroutine_r,
  output reg push_reg_r,
  output reg pop_reg_r,
  output reg load_after_push_r,
  output reg [7:0] trap_num_r,
  output reg [3:0] reg_a_r,
  output reg [3:0] reg_b_r,
  output reg [15:0] operand_r,
  output reg no_effect_r,
  output reg illegal_r,
  output reg ovr_active_r,
  output reg ovr_kind_r,
  output reg ovr_regext_r
);

  // ----
  // Helpers
  // ----
  function four_bytes;
    input [1:0] rule;
    input v1;
    begin
      case (rule)
        `LR_FOUR: four_bytes = 1'b1;
        `LR_BY_V1: four_bytes = v1;
        default: four_bytes = 1'b0;
      endcase
    end
  endfunction

  function bad_variant;
    input [5:0] cl;
    input [1:0] v;
    begin
      case (cl)
        `CL_BITLOG: bad_variant = (v == `VAR_BAD);
        `CL_JMPC: bad_variant = (v == `VAR_BAD);
        `CL_CALLC: bad_variant = (v == `VAR_BAD);
        default: bad_variant = 1'b0;
      endcase
    end
  endfunction

  // ----
  // Sequencer state
  // ----
  reg [1:0] state_r;
  reg [15:0] word1_r;
  reg [15:0] word2_r;
  reg four_r;
  wire [7:0] rom_data;
  wire [5:0] rom_class;
  wire [1:0] rom_rule;
  wire take1;
  wire take2;
  wire emit;
  wire [1:0] var_bits;
  wire ov_active;
  wire ov_kind;
  wire ov_regext;
  wire ov_start;
  wire [2:0] ov_count;
  wire len4;

  assign take1 = (state_r == `ST_IDLE) && fw_valid && fetch_ready_r;
  assign take2 = (state_r == `ST_WAIT2) && fw_valid && fetch_ready_r;
  assign emit = (state_r == `ST_EMIT);
  assign rom_class = rom_data[5:0];
  assign rom_rule = rom_data[7:6];
  assign var_bits = {word1_r[`OPC_V1], word1_r[`OPC_V0]};
  // A bad variant is illegal and so always two bytes long
  assign len4 = four_bytes(rom_rule, word1_r[`OPC_V1]) && !bad_variant(rom_class, var_bits);

  class_rom u_rom (
    .mclk(mclk),
    .arst_n(arst_n),
    .rd_en(take1),
    .rd_addr(fw_data[`OPC_TOP_HI:`OPC_TOP_LO]),
    .rd_data_r(rom_data)
  );

  // Held class stays valid after the lookup since the table is only read on take1
  assign ov_start = emit && ((rom_class == `CL_EXTP) || (rom_class == `CL_EXTS));
  assign ov_count = {1'b0, word1_r[`OVC_HI:`OVC_LO]} + `OV_ONE;

  override_track u_ovr (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(ov_start),
    .step(emit && !ov_start),
    .count(ov_count),
    .kind((rom_class == `CL_EXTS) ? `OVK_SEG : `OVK_PAGE),
    .regext(word1_r[`OPC_V0]),
    .active(ov_active),
    .kind_r(ov_kind),
    .regext_r(ov_regext)
  );

  // ----
  // Fetch handshake and length
  // ----
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= `ST_IDLE;
      fetch_ready_r <= 1'b1;
      word1_r <= `Z16;
      word2_r <= `Z16;
      four_r <= 1'b0;
      len_valid_r <= 1'b0;
      len_four_r <= 1'b0;
    end
    else
    begin
      len_valid_r <= 1'b0;
      case (state_r)
        `ST_IDLE:
        begin
          if (take1)
          begin
            word1_r <= fw_data;
            word2_r <= `Z16;
            fetch_ready_r <= 1'b0;
            state_r <= `ST_LOOK;
          end
        end
        `ST_LOOK:
        begin
          // Length goes out before any operand word is accepted
          four_r <= len4;
          len_four_r <= len4;
          len_valid_r <= 1'b1;
          if (len4)
          begin
            fetch_ready_r <= 1'b1;
            state_r <= `ST_WAIT2;
          end
          else
            state_r <= `ST_EMIT;
        end
        `ST_WAIT2:
        begin
          if (take2)
          begin
            word2_r <= fw_data;
            fetch_ready_r <= 1'b0;
            state_r <= `ST_EMIT;
          end
        end
        `ST_EMIT:
        begin
          fetch_ready_r <= 1'b1;
          state_r <= `ST_IDLE;
        end
        default:
        begin
          fetch_ready_r <= 1'b1;
          state_r <= `ST_IDLE;
        end
      endcase
    end
  end

  // ----
  // Classification
  // ----
  reg [5:0] cls_nxt;
  reg illegal_nxt;
  reg byte_nxt;
  reg carry_nxt;
  reg sub_nxt;
  reg uns_nxt;
  reg low_nxt;
  reg neg_nxt;
  reg side_w_nxt;
  reg side_v_nxt;
  reg high_nxt;
  reg up_nxt;
  reg two_nxt;
  reg right_nxt;
  reg arith_nxt;
  reg zext_nxt;
  reg br_nxt;
  reg subr_nxt;
  reg push_nxt;
  reg pop_nxt;
  reg load_nxt;
  reg none_nxt;
  reg [7:0] trap_nxt;

  always @*
  begin
    illegal_nxt = (rom_class == `CL_ILLEGAL) || bad_variant(rom_class, var_bits);
    cls_nxt = illegal_nxt ? `CL_ILLEGAL : rom_class;
    byte_nxt = 1'b0;
    carry_nxt = 1'b0;
    sub_nxt = 1'b0;
    uns_nxt = 1'b0;
    low_nxt = 1'b0;
    neg_nxt = 1'b0;
    side_w_nxt = 1'b0;
    side_v_nxt = 1'b0;
    high_nxt = 1'b0;
    up_nxt = 1'b0;
    two_nxt = 1'b0;
    right_nxt = 1'b0;
    arith_nxt = 1'b0;
    zext_nxt = 1'b0;
    br_nxt = 1'b0;
    subr_nxt = 1'b0;
    push_nxt = 1'b0;
    pop_nxt = 1'b0;
    load_nxt = 1'b0;
    none_nxt = illegal_nxt;
    trap_nxt = `Z8;
    case (cls_nxt)
      `CL_ADD, `CL_ADDC, `CL_SUB, `CL_SUBC:
      begin
        byte_nxt = word1_r[`OPC_V0];
        carry_nxt = (cls_nxt == `CL_ADDC) || (cls_nxt == `CL_SUBC);
        sub_nxt = (cls_nxt == `CL_SUB) || (cls_nxt == `CL_SUBC);
      end
      `CL_MUL: uns_nxt = word1_r[`OPC_V0];
      `CL_DIV:
      begin
        uns_nxt = word1_r[`OPC_V0];
        low_nxt = 1'b1;
      end
      `CL_DIVL: uns_nxt = word1_r[`OPC_V0];
      `CL_BITWR: side_v_nxt = word1_r[`OPC_V0];
      `CL_BITCPY: neg_nxt = word1_r[`OPC_V0];
      `CL_BFLD: high_nxt = word1_r[`OPC_V0];
      `CL_CMPD, `CL_CMPI:
      begin
        up_nxt = (cls_nxt == `CL_CMPI);
        two_nxt = word1_r[`OPC_V0];
      end
      `CL_LSH, `CL_ROT: right_nxt = word1_r[`OPC_V0];
      `CL_SIGN_SHIFT_RIGHT:
      begin
        right_nxt = 1'b1;
        arith_nxt = 1'b1;
      end
      `CL_MOVX:
      begin
        byte_nxt = 1'b1;
        zext_nxt = word1_r[`OPC_V0];
      end
      `CL_JMPC: br_nxt = cond_true;
      `CL_CALLC:
      begin
        br_nxt = cond_true;
        subr_nxt = cond_true;
      end
      `CL_JB:
      begin
        // Tested bit is cleared when variant bit OPC_V0 is set, independent of the branch, which is always flagged
        br_nxt = 1'b1;
        side_w_nxt = word1_r[`OPC_V0];
        side_v_nxt = 1'b0;
      end
      `CL_JNB:
      begin
        br_nxt = 1'b1;
        side_w_nxt = word1_r[`OPC_V0];
        side_v_nxt = 1'b1;
      end
      `CL_TRAP:
      begin
        subr_nxt = 1'b1;
        trap_nxt = word1_r[`OPB_HI:`OPB_LO];
      end
      `CL_SWITCH_CONTEXT_PUSH:
      begin
        push_nxt = 1'b1;
        load_nxt = 1'b1;
      end
      `CL_PUSH_AND_ENTER_SUB:
      begin
        push_nxt = 1'b1;
        br_nxt = 1'b1;
        subr_nxt = 1'b1;
      end
      `CL_RET:
      begin
        br_nxt = 1'b1;
        pop_nxt = word1_r[`OPC_V0];
      end
      `CL_EXTP, `CL_EXTS: none_nxt = 1'b0;
      `CL_SLEEP: none_nxt = 1'b1;
      `CL_NOP: none_nxt = 1'b1;
      default: none_nxt = 1'b1;
    endcase
  end

  // ----
  // Decoded outputs, one-cycle pulse per instruction
  // ----
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dec_valid_r <= 1'b0;
      op_class_r <= `CL_NOP;
      byte_op_r <= 1'b0;
      use_carry_r <= 1'b0;
      subtract_r <= 1'b0;
      unsigned_op_r <= 1'b0;
      low_half_only_r <= 1'b0;
      variant_r <= `Z2;
      bit_negate_r <= 1'b0;
      bit_side_write_r <= 1'b0;
      bit_side_value_r <= 1'b0;
      byte_high_r <= 1'b0;
      step_up_r <= 1'b0;
      step_two_r <= 1'b0;
      shift_right_r <= 1'b0;
      shift_arith_r <= 1'b0;
      zero_extend_r <= 1'b0;
      branch_en_r <= 1'b0;
      subroutine_r <= 1'b0;
      push_reg_r <= 1'b0;
      pop_reg_r <= 1'b0;
      load_after_push_r <= 1'b0;
      trap_num_r <= `Z8;
      reg_a_r <= `Z4;
      reg_b_r <= `Z4;
      operand_r <= `Z16;
      no_effect_r <= 1'b0;
      illegal_r <= 1'b0;
      ovr_active_r <= 1'b0;
      ovr_kind_r <= `OVK_PAGE;
      ovr_regext_r <= 1'b0;
    end
    else
    begin
      dec_valid_r <= emit;
      if (emit)
      begin
        op_class_r <= cls_nxt;
        byte_op_r <= byte_nxt;
        use_carry_r <= carry_nxt;
        subtract_r <= sub_nxt;
        unsigned_op_r <= uns_nxt;
        low_half_only_r <= low_nxt;
        variant_r <= var_bits;
        bit_negate_r <= neg_nxt;
        bit_side_write_r <= side_w_nxt;
        bit_side_value_r <= side_v_nxt;
        byte_high_r <= high_nxt;
        step_up_r <= up_nxt;
        step_two_r <= two_nxt;
        shift_right_r <= right_nxt;
        shift_arith_r <= arith_nxt;
        zero_extend_r <= zext_nxt;
        branch_en_r <= br_nxt;
        subroutine_r <= subr_nxt;
        push_reg_r <= push_nxt;
        pop_reg_r <= pop_nxt;
        load_after_push_r <= load_nxt;
        trap_num_r <= trap_nxt;
        reg_a_r <= word1_r[`REGA_HI:`REGA_LO];
        reg_b_r <= word1_r[`REGB_HI:`REGB_LO];
        operand_r <= four_r ? word2_r : `Z16;
        no_effect_r <= none_nxt;
        illegal_r <= illegal_nxt;
        // Override state before this instruction's own step
        ovr_active_r <= ov_active && !ov_start;
        ovr_kind_r <= ov_kind;
        ovr_regext_r <= ov_regext;
      end
    end
  end

endmodule

// ==== isd_consts.vh ====
// Constants shared by the instruction length decoder and its helpers.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef ISD_CONSTS_VH
`define ISD_CONSTS_VH

// ----
// Fetch word fields (first word: opcode byte high, operand byte low)
// ----
`define OPC_TOP_HI 15
`define OPC_TOP_LO 10
`define OPC_V1 9
`define OPC_V0 8
`define OPB_HI 7
`define OPB_LO 0
`define REGA_HI 7
`define REGA_LO 4
`define REGB_HI 3
`define REGB_LO 0
`define OVC_HI 5
`define OVC_LO 4

// ----
// Class codes (6 bits)
// ----
`define CL_ADD 6'h00
`define CL_ADDC 6'h01
`define CL_SUB 6'h02
`define CL_SUBC 6'h03
`define CL_MUL 6'h04
`define CL_DIV 6'h05
`define CL_DIVL 6'h06
`define CL_BITWR 6'h07
`define CL_BITCPY 6'h08
`define CL_BITLOG 6'h09
`define CL_BITCMP 6'h0A
`define CL_BFLD 6'h0B
`define CL_CMPD 6'h0C
`define CL_CMPI 6'h0D
`define CL_NORM 6'h0E
`define CL_LSH 6'h0F
`define CL_ROT 6'h10
`define CL_SIGN_SHIFT_RIGHT 6'h11
`define CL_MOVX 6'h12
`define CL_JMPC 6'h13
`define CL_CALLC 6'h14
`define CL_JB 6'h15
`define CL_JNB 6'h16
`define CL_TRAP 6'h17
`define CL_SWITCH_CONTEXT_PUSH 6'h18
`define CL_PUSH_AND_ENTER_SUB 6'h19
`define CL_RET 6'h1A
`define CL_EXTP 6'h1B
`define CL_EXTS 6'h1C
`define CL_SLEEP 6'h1D
`define CL_NOP 6'h1E
`define CL_ILLEGAL 6'h1F

// ----------------------------------------------------------------
// Length rule stored with each class in the table
// ----------------------------------------------------------------
`define LR_TWO 2'h0
`define LR_FOUR 2'h1
`define LR_BY_V1 2'h2

// ----------------------------------------------------------------
// Opcode top six bits (opcode byte bits 7..2)
// ----------------------------------------------------------------
`define OP_ADD 6'h00
`define OP_ADDC 6'h01
`define OP_SUB 6'h02
`define OP_SUBC 6'h03
`define OP_MUL 6'h04
`define OP_DIV 6'h05
`define OP_DIVL 6'h06
`define OP_BITWR 6'h07
`define OP_BITCPY 6'h08
`define OP_BITLOG 6'h09
`define OP_BITCMP 6'h0A
`define OP_BFLD 6'h0B
`define OP_CMPD 6'h0C
`define OP_CMPI 6'h0D
`define OP_NORM 6'h0E
`define OP_LSH 6'h0F
`define OP_ROT 6'h10
`define OP_SIGN_SHIFT_RIGHT 6'h11
`define OP_MOVX 6'h12
`define OP_JMPC 6'h13
`define OP_CALLC 6'h14
`define OP_JB 6'h15
`define OP_JNB 6'h16
`define OP_TRAP 6'h17
`define OP_SWITCH_CONTEXT_PUSH 6'h18
`define OP_PUSH_AND_ENTER_SUB 6'h19
`define OP_RET 6'h1A
`define OP_EXTP 6'h1B
`define OP_EXTS 6'h1C
`define OP_SLEEP 6'h1D
`define OP_NOP 6'h1E

// ----------------------------------------------------------------
// Variant codes and reset values
// ----------------------------------------------------------------
`define BL_AND 2'h0
`define BL_OR 2'h1
`define BL_XOR 2'h2
`define BR_ABS 2'h0
`define BR_IND 2'h1
`define BR_REL 2'h2
`define VAR_BAD 2'h3
`define OVK_PAGE 1'b0
`define OVK_SEG 1'b1
`define Z16 16'h0000
`define Z8 8'h00
`define Z6 6'h00
`define Z4 4'h0
`define Z3 3'h0
`define Z2 2'h0
`define OV_ONE 3'h1

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define ST_IDLE 2'h0
`define ST_LOOK 2'h1
`define ST_WAIT2 2'h2
`define ST_EMIT 2'h3

`endif

// ==== class_rom.v ====
// Opcode class table: maps opcode bits 7..2 to length rule and class.
// Assumes one clock; read data is registered, valid one cycle after rd_en.
`timescale 1ns/1ps
`include "isd_consts.vh"

module class_rom (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Read port
  input wire rd_en,
  input wire [5:0] rd_addr,
  output reg [7:0] rd_data_r
);

  // Unlisted patterns all land on one illegal entry of two bytes
  function [7:0] entry;
    input [5:0] a;
    begin
      case (a)
        `OP_ADD: entry = {`LR_BY_V1, `CL_ADD};
        `OP_ADDC: entry = {`LR_BY_V1, `CL_ADDC};
        `OP_SUB: entry = {`LR_BY_V1, `CL_SUB};
        `OP_SUBC: entry = {`LR_BY_V1, `CL_SUBC};
        `OP_MUL: entry = {`LR_TWO, `CL_MUL};
        `OP_DIV: entry = {`LR_TWO, `CL_DIV};
        `OP_DIVL: entry = {`LR_TWO, `CL_DIVL};
        `OP_BITWR: entry = {`LR_TWO, `CL_BITWR};
        `OP_BITCPY: entry = {`LR_FOUR, `CL_BITCPY};
        `OP_BITLOG: entry = {`LR_FOUR, `CL_BITLOG};
        `OP_BITCMP: entry = {`LR_FOUR, `CL_BITCMP};
        `OP_BFLD: entry = {`LR_FOUR, `CL_BFLD};
        `OP_CMPD: entry = {`LR_BY_V1, `CL_CMPD};
        `OP_CMPI: entry = {`LR_BY_V1, `CL_CMPI};
        `OP_NORM: entry = {`LR_TWO, `CL_NORM};
        `OP_LSH: entry = {`LR_TWO, `CL_LSH};
        `OP_ROT: entry = {`LR_TWO, `CL_ROT};
        `OP_SIGN_SHIFT_RIGHT: entry = {`LR_TWO, `CL_SIGN_SHIFT_RIGHT};
        `OP_MOVX: entry = {`LR_BY_V1, `CL_MOVX};
        `OP_JMPC: entry = {`LR_FOUR, `CL_JMPC};
        `OP_CALLC: entry = {`LR_FOUR, `CL_CALLC};
        `OP_JB: entry = {`LR_FOUR, `CL_JB};
        `OP_JNB: entry = {`LR_FOUR, `CL_JNB};
        `OP_TRAP: entry = {`LR_TWO, `CL_TRAP};
        `OP_SWITCH_CONTEXT_PUSH: entry = {`LR_FOUR, `CL_SWITCH_CONTEXT_PUSH};
        `OP_PUSH_AND_ENTER_SUB: entry = {`LR_FOUR, `CL_PUSH_AND_ENTER_SUB};
        `OP_RET: entry = {`LR_TWO, `CL_RET};
        `OP_EXTP: entry = {`LR_BY_V1, `CL_EXTP};
        `OP_EXTS: entry = {`LR_BY_V1, `CL_EXTS};
        `OP_SLEEP: entry = {`LR_FOUR, `CL_SLEEP};
        `OP_NOP: entry = {`LR_TWO, `CL_NOP};
        default: entry = {`LR_TWO, `CL_ILLEGAL};
      endcase
    end
  endfunction

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_r <= {`LR_TWO, `CL_NOP};
    else if (rd_en)
      rd_data_r <= entry(rd_addr);
  end

endmodule

// ==== override_track.v ====
// Tracks an open page or segment override over the following instructions.
// Assumes start and step pulses come from the sequencer, never together.
`timescale 1ns/1ps
`include "isd_consts.vh"

module override_track (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Control from sequencer
  input wire start,
  input wire step,
  input wire [2:0] count,
  input wire kind,
  input wire regext,
  // State
  output wire active,
  output reg kind_r,
  output reg regext_r
);

  reg [2:0] left_r;

  assign active = (left_r != `Z3);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left_r <= `Z3;
      kind_r <= `OVK_PAGE;
      regext_r <= 1'b0;
    end
    else if (start)
    begin
      // A new opener replaces any sequence still open
      left_r <= count;
      kind_r <= kind;
      regext_r <= regext;
    end
    else if (step && active)
      left_r <= left_r - `OV_ONE;
  end

endmodule

// ==== insn_decoder_checker.sv ====
// Checker for the instruction length decoder: handshake timing and class lengths.
// Assumes it is bound to insn_decoder and sees only that module's ports.
`timescale 1ns/1ps
`include "isd_consts.vh"
module insn_decoder_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fetch side
  input wire logic fw_valid,
  input wire logic [15:0] fw_data,
  input wire logic fetch_ready_r,
  input wire logic len_valid_r,
  input wire logic len_four_r,
  input wire logic cond_true,
  // Decoded side
  input wire logic dec_valid_r,
  input wire logic [5:0] op_class_r,
  input wire logic branch_en_r,
  input wire logic [7:0] trap_num_r,
  input wire logic no_effect_r,
  input wire logic illegal_r,
  input wire logic ovr_active_r
);
  // ----
  // Word tracking
  // ----
  logic w2p_r;
  logic [15:0] w1_r;
  wire take1 = fw_valid && fetch_ready_r && !w2p_r;
  wire take2 = fw_valid && fetch_ready_r && w2p_r;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      w2p_r <= 1'b0;
      w1_r <= 16'h0000;
    end
    else
    begin
      if (take1)
        w1_r <= fw_data;
      if (len_valid_r && len_four_r)
        w2p_r <= 1'b1;
      else if (take2)
        w2p_r <= 1'b0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  word1_len_a: assert property (take1 |-> ##2 len_valid_r)
    else $error("length flag late");
  short_dec_a: assert property (take1 ##2 (len_valid_r && !len_four_r) |-> ##1 (dec_valid_r && fetch_ready_r))
    else $error("short decode late");
  long_dec_a: assert property (take2 |-> ##2 dec_valid_r)
    else $error("long decode late");
  ready_drop_a: assert property (fw_valid && fetch_ready_r |=> !fetch_ready_r)
    else $error("ready held after take");
  len_pulse_a: assert property (len_valid_r |=> !len_valid_r && $stable(len_four_r))
    else $error("length flag shape");
  illegal_len_a: assert property (dec_valid_r && illegal_r |-> !len_four_r && no_effect_r && op_class_r == `CL_ILLEGAL)
    else $error("illegal policy broken");
  sleep_noeff_a: assert property (dec_valid_r && op_class_r == `CL_SLEEP |-> len_four_r && no_effect_r)
    else $error("sleep decode wrong");
  four_class_a: assert property (dec_valid_r && op_class_r inside {`CL_BITCPY, `CL_BITLOG, `CL_BITCMP, `CL_BFLD,
    `CL_JMPC, `CL_CALLC, `CL_JB, `CL_JNB, `CL_SWITCH_CONTEXT_PUSH, `CL_PUSH_AND_ENTER_SUB} |-> len_four_r)
    else $error("four byte class short");
  two_class_a: assert property (dec_valid_r && op_class_r inside {`CL_MUL, `CL_DIV, `CL_DIVL, `CL_BITWR, `CL_NORM,
    `CL_LSH, `CL_ROT, `CL_SIGN_SHIFT_RIGHT, `CL_TRAP, `CL_RET} |-> !len_four_r)
    else $error("two byte class long");
  cond_branch_a: assert property (dec_valid_r && !illegal_r && op_class_r inside {`CL_JMPC, `CL_CALLC}
    |-> branch_en_r == $past(cond_true))
    else $error("branch ignores condition");
  trap_num_a: assert property (dec_valid_r && op_class_r == `CL_TRAP |-> trap_num_r == w1_r[7:0])
    else $error("trap number wrong");
  cover property (take2);
  cover property (dec_valid_r && illegal_r);
  cover property (dec_valid_r && ovr_active_r);
endmodule

bind insn_decoder insn_decoder_checker chk_u (.*);

// ==== fetch_model.sv ====
// Fetch unit model: offers opcode and operand words to the decoder.
// Assumes the decoder's length flag decides whether a second word follows.
`timescale 1ns/1ps
module fetch_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Decoder handshake
  input wire logic fetch_ready_r,
  input wire logic len_valid_r,
  input wire logic len_four_r,
  output logic fw_valid,
  output logic [15:0] fw_data
);
  initial
  begin
    fw_valid = 1'b0;
    fw_data = 16'h0000;
  end
  // Word is held until the edge that samples ready high
  task put(input logic [15:0] w, input integer gap, output logic ok);
    integer i;
    begin
      ok = 1'b0;
      @(negedge mclk);
      repeat (gap) @(negedge mclk);
      fw_valid = 1'b1;
      fw_data = w;
      for (i = 0; i < 40 && !ok; i = i + 1)
      begin
        if (fetch_ready_r)
          ok = 1'b1;
        else
          @(negedge mclk);
      end
      @(posedge mclk);
    end
  endtask
  // Released bus shows the inverse, so a stale word never passes as fresh
  task rel;
    begin
      @(negedge mclk);
      fw_valid = 1'b0;
      fw_data = ~fw_data;
    end
  endtask
  task send(input logic [15:0] w1, input logic [15:0] w2, input integer gap, output logic ok);
    integer i;
    begin
      put(w1, gap, ok);
      rel;
      for (i = 0; i < 8 && len_valid_r !== 1'b1; i = i + 1)
        @(negedge mclk);
      if (len_valid_r !== 1'b1)
        ok = 1'b0;
      else if (len_four_r)
      begin
        put(w2, gap, ok);
        rel;
      end
    end
  endtask
endmodule

// ==== insn_decoder_test.sv ====
// Testbench for the instruction length decoder, with a fetch unit model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`include "isd_consts.vh"
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module insn_decoder_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cond_true = 1'b0;
  wire fw_valid, fetch_ready_r, len_valid_r, len_four_r, dec_valid_r, byte_op_r, use_carry_r, subtract_r;
  wire unsigned_op_r, low_half_only_r, bit_negate_r, bit_side_write_r, bit_side_value_r, byte_high_r, step_up_r;
  wire step_two_r, shift_right_r, shift_arith_r, zero_extend_r, branch_en_r, subroutine_r, push_reg_r, pop_reg_r;
  wire load_after_push_r, no_effect_r, illegal_r, ovr_active_r, ovr_kind_r, ovr_regext_r;
  wire [15:0] fw_data, operand_r;
  wire [5:0] op_class_r;
  wire [1:0] variant_r;
  wire [7:0] trap_num_r;
  wire [3:0] reg_a_r, reg_b_r;
  integer num_errors = 0;
  integer n_tests = 0;
  integer k;
  logic ok;
  always #50 mclk = ~mclk;
  insn_decoder dut_u (.*);
  fetch_model fetch_u (.*);
  task give_verdict;
    begin
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // One instruction through the fetch model, then wait for its decode pulse
  task run(input logic [15:0] w1, input logic [15:0] w2, input integer gap);
    integer i;
    begin
      fetch_u.send(w1, w2, gap, ok);
      for (i = 0; i < 8 && dec_valid_r !== 1'b1; i = i + 1)
        @(negedge mclk);
      if (!ok || dec_valid_r !== 1'b1)
      begin
        $display("[FAIL] handshake exp 1 got 0");
        num_errors = num_errors + 1;
        give_verdict;
      end
    end
  endtask
  task t_arith;
    logic [5:0] ops [0:3];
    begin
      ops = '{`OP_ADD, `OP_ADDC, `OP_SUB, `OP_SUBC};
      for (k = 0; k < 16; k = k + 1)
      begin
        run({ops[k / 4], k[1:0], 8'h21}, 16'hA55A, 0);
        `CHK("len_four", k[1], len_four_r)
        `CHK("byte_op", k[0], byte_op_r)
        `CHK("carry", k[2], use_carry_r)
        `CHK("subtract", k[3], subtract_r)
        `CHK("operand", k[1] ? 16'hA55A : 16'h0000, operand_r)
      end
    end
  endtask
  task t_table;
    logic [5:0] ops [0:16];
    logic [5:0] cls [0:16];
    logic [16:0] four;
    begin
      ops = '{`OP_MUL, `OP_DIV, `OP_DIVL, `OP_BITWR, `OP_BITCPY, `OP_BITLOG, `OP_BITCMP, `OP_BFLD, `OP_NORM,
        `OP_LSH, `OP_ROT, `OP_SIGN_SHIFT_RIGHT, `OP_TRAP, `OP_SWITCH_CONTEXT_PUSH, `OP_PUSH_AND_ENTER_SUB, `OP_RET, `OP_SLEEP};
      cls = '{`CL_MUL, `CL_DIV, `CL_DIVL, `CL_BITWR, `CL_BITCPY, `CL_BITLOG, `CL_BITCMP, `CL_BFLD, `CL_NORM,
        `CL_LSH, `CL_ROT, `CL_SIGN_SHIFT_RIGHT, `CL_TRAP, `CL_SWITCH_CONTEXT_PUSH, `CL_PUSH_AND_ENTER_SUB, `CL_RET, `CL_SLEEP};
      four = 17'b1_0110_0000_1111_0000;
      for (k = 0; k < 17; k = k + 1)
      begin
        run({ops[k], 2'b01, 8'h3C}, 16'h0F0F, k % 3);
        `CHK("class", cls[k], op_class_r)
        `CHK("len_four", four[k], len_four_r)
        if (k == 0) `CHK("unsigned", 1'b1, unsigned_op_r)
        if (k < 3) `CHK("low_half", k == 1, low_half_only_r)
        if (k == 7) `CHK("byte_high", 1'b1, byte_high_r)
        if (k == 11) `CHK("arith", 1'b1, shift_arith_r)
        if (k == 12) `CHK("trap", 8'h3C, trap_num_r)
        if (k == 13) `CHK("load", 1'b1, load_after_push_r)
        if (k == 14) `CHK("push", 1'b1, push_reg_r)
        if (k == 15) `CHK("pop", 1'b1, pop_reg_r)
      end
    end
  endtask
  task t_branch;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        cond_true = k[0] ^ k[1];
        run({k[2] ? `OP_CALLC : `OP_JMPC, k[1:0], 8'h10}, 16'h1234, 1);
        if (k[1:0] == 2'b11) `CHK("illegal", 1'b1, illegal_r)
        else `CHK("taken", k[0] ^ k[1], branch_en_r)
      end
      run({`OP_JB, 2'b01, 8'h10}, 16'h0001, 0);
      `CHK("bit_wr", 1'b1, bit_side_write_r)
      `CHK("bit_val", 1'b0, bit_side_value_r)
      run({`OP_JNB, 2'b01, 8'h10}, 16'h0001, 0);
      `CHK("bit_val", 1'b1, bit_side_value_r)
    end
  endtask
  task t_odd;
    begin
      run({6'h3F, 2'b00, 8'h00}, 16'h0000, 0);
      `CHK("class", `CL_ILLEGAL, op_class_r)
      run({`OP_MOVX, 2'b11, 8'h45}, 16'h00F0, 2);
      `CHK("zero_ext", 1'b1, zero_extend_r)
      `CHK("len_four", 1'b1, len_four_r)
      run({`OP_CMPD, 2'b01, 8'h45}, 16'h0000, 0);
      `CHK("step", 2'b01, {step_up_r, step_two_r})
      run({`OP_CMPI, 2'b00, 8'h45}, 16'h0000, 0);
      `CHK("step", 2'b10, {step_up_r, step_two_r})
    end
  endtask
  task t_override;
    begin
      run({`OP_EXTP, 2'b01, 8'h10}, 16'h0000, 0);
      `CHK("ovr_self", 1'b0, ovr_active_r)
      for (k = 0; k < 3; k = k + 1)
      begin
        run({`OP_NOP, 2'b00, 8'h00}, 16'h0000, 0);
        `CHK("ovr_on", k < 2, ovr_active_r)
        if (k == 0) `CHK("ovr_ext", 2'b01, {ovr_kind_r, ovr_regext_r})
      end
      run({`OP_EXTS, 2'b10, 8'h00}, 16'h0300, 0);
      `CHK("len_four", 1'b1, len_four_r)
      run({`OP_NOP, 2'b00, 8'h00}, 16'h0000, 0);
      `CHK("ovr_seg", 2'b11, {ovr_active_r, ovr_kind_r})
    end
  endtask
  // Reset lands between opcode and operand word
  task t_reset;
    begin
      fetch_u.put({`OP_SWITCH_CONTEXT_PUSH, 2'b00, 8'h10}, 0, ok);
      fetch_u.rel;
      arst_n = 1'b0;
      #10;
      `CHK("ready", 1'b1, fetch_ready_r)
      `CHK("class", `CL_NOP, op_class_r)
      `CHK("ovr_kind", 1'b0, ovr_kind_r)
      @(negedge mclk);
      arst_n = 1'b1;
      run({`OP_SWITCH_CONTEXT_PUSH, 2'b00, 8'h10}, 16'hBEEF, 0);
      `CHK("operand", 16'hBEEF, operand_r)
    end
  endtask
  initial
  begin
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    t_arith;
    t_table;
    t_branch;
    t_odd;
    t_override;
    t_reset;
    give_verdict;
  end
endmodule
